// ### design/wdw_watchdog.sv
// Behaviour
// R1: when enabled the counter keeps running in sleep and in idle.
// R2: a time-out in sleep or idle wakes the core with no device reset.
// R3: software clears the sleep or idle flag after a watchdog wake-up.
// R4: with always_on_cfg set the watchdog runs and the soft enable is ignored.
// R5: software control applies only while always_on_cfg is zero.
// R6: under software control the watchdog runs exactly while the enable is one.
// R7: every device reset forces the soft enable bit to zero.
// R8: a time-out sets a sticky flag that only software clears.
// R9: window_off_cfg zero selects windowed mode, one selects plain mode.
// R10: in windowed mode software clears only inside the selected window.
// R11: the oscillator clocks the counter and is on whenever it is enabled.
// R12: a 32 or 128 prescaler feeds a postscaler of 1:1 up to 1:32768.
// R13: reset, clock switch, power-save entry, wake and clear zero the counter.
// R14: a time-out in normal run requests a device reset and sets the flag.
// R15: a clear before the window opens requests a device reset.
`timescale 1ns/100ps
module wdw_watchdog import wdw_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration word
    input wire logic always_on_cfg,
    input wire logic window_off_cfg,
    input wire logic [1:0] window_size_sel,
    input wire logic prescale_sel,
    input wire logic [3:0] postscale_sel,
    // core events, one-cycle pulses; power_save_idle is a level select
    input wire logic clear_dog_instr,
    input wire logic power_save_instr,
    input wire logic power_save_idle,
    input wire logic wake_event,
    input wire logic clock_switch_done,
    input wire logic ext_reset,
    // reset control register writes
    input wire logic soft_enable_wr,
    input wire logic soft_enable_wdata,
    input wire logic timeout_flag_clr,
    input wire logic sleep_flag_clr,
    input wire logic idle_flag_clr,
    // reset control register bits
    output logic soft_enable_bit,
    output logic timeout_flag,
    output logic sleep_flag,
    output logic idle_flag,
    // power and reset outputs
    output logic osc_en,
    output logic core_halted,
    output logic wake_pulse,
    output logic dev_reset_req
);

    wdw_pwr_t pwr_reg, pwr_next;
    logic soft_enable_reg, soft_enable_next;
    logic timeout_flag_reg, timeout_flag_next;
    logic sleep_flag_reg, sleep_flag_next;
    logic idle_flag_reg, idle_flag_next;
    logic osc_en_reg, osc_en_next;
    logic halted_reg, halted_next;
    logic wake_reg, wake_next;
    logic dev_reset_reg, dev_reset_next;

    logic running;
    logic enabled;
    logic enter_save;
    logic wake_now;
    logic win_fault;
    logic wdt_reset;
    logic dev_rst_now;
    logic scl_clr;
    logic tmo;
    logic [POST_W-1:0] post_count;

    assign soft_enable_bit = soft_enable_reg;
    assign timeout_flag = timeout_flag_reg;
    assign sleep_flag = sleep_flag_reg;
    assign idle_flag = idle_flag_reg;
    assign osc_en = osc_en_reg;
    assign core_halted = halted_reg;
    assign wake_pulse = wake_reg;
    assign dev_reset_req = dev_reset_reg;

    // enable decode: the fuse overrides software
    assign enabled = always_on_cfg || soft_enable_reg; // R4 R5 R6
    assign running = (pwr_reg == PWR_RUN);
    assign enter_save = power_save_instr && running;
    assign wake_now = !running && (tmo || wake_event); // R2
    // early clear is only a fault while the dog is actually counting
    assign win_fault = clear_dog_instr && running && enabled
        && !window_off_cfg
        && (post_count < win_open(post_limit(postscale_sel),
                                  window_size_sel)); // R9 R15
    assign wdt_reset = (tmo && running) || win_fault; // R14
    assign dev_rst_now = ext_reset || wdt_reset;
    // a stopped dog restarts from zero rather than from a stale count
    assign scl_clr = dev_rst_now || clock_switch_done || enter_save
        || wake_now || (clear_dog_instr && running)
        || !enabled; // R13

    wdw_scaler u_scaler (
        .clk(clk),
        .rst(rst),
        .clr(scl_clr),
        .run(osc_en_reg),
        .prescale_sel(prescale_sel),
        .postscale_sel(postscale_sel),
        .tmo(tmo),
        .post_count(post_count)
    );

    // power state, enable and status bits
    always_comb begin
        pwr_next = pwr_reg;
        soft_enable_next = soft_enable_reg;
        case (pwr_reg)
            PWR_RUN: begin
                if (enter_save) begin
                    pwr_next = power_save_idle ? PWR_IDLE : PWR_SLEEP;
                end
            end
            PWR_SLEEP, PWR_IDLE: begin
                if (wake_now) begin // R1 R2
                    pwr_next = PWR_RUN;
                end
            end
            default: pwr_next = PWR_RUN;
        endcase
        if (soft_enable_wr) begin
            soft_enable_next = soft_enable_wdata;
        end
        if (dev_rst_now) begin
            pwr_next = PWR_RUN;
            soft_enable_next = 1'b0; // R7
        end
        // set wins over a clear arriving in the same cycle
        timeout_flag_next = tmo
            || (timeout_flag_reg && !timeout_flag_clr); // R8
        sleep_flag_next = (enter_save && !power_save_idle)
            || (sleep_flag_reg && !sleep_flag_clr); // R3
        idle_flag_next = (enter_save && power_save_idle)
            || (idle_flag_reg && !idle_flag_clr); // R3
        osc_en_next = enabled; // R11
        halted_next = (pwr_next != PWR_RUN);
        wake_next = wake_now && !dev_rst_now;
        dev_reset_next = wdt_reset;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwr_reg <= PWR_RUN;
            soft_enable_reg <= 1'b0;
            timeout_flag_reg <= 1'b0;
            sleep_flag_reg <= 1'b0;
            idle_flag_reg <= 1'b0;
            osc_en_reg <= 1'b0;
            halted_reg <= 1'b0;
            wake_reg <= 1'b0;
            dev_reset_reg <= 1'b0;
        end else begin
            pwr_reg <= pwr_next;
            soft_enable_reg <= soft_enable_next;
            timeout_flag_reg <= timeout_flag_next;
            sleep_flag_reg <= sleep_flag_next;
            idle_flag_reg <= idle_flag_next;
            osc_en_reg <= osc_en_next;
            halted_reg <= halted_next;
            wake_reg <= wake_next;
            dev_reset_reg <= dev_reset_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // a watchdog reset in the entry cycle keeps the core running
    sequence s_enter_sleep;
        enter_save && !power_save_idle && !dev_rst_now;
    endsequence

    sequence s_enter_idle;
        enter_save && power_save_idle && !dev_rst_now;
    endsequence

    sequence s_sleep_tmo;
        !running && tmo && !ext_reset;
    endsequence

    a_enter_sleep: assert property (s_enter_sleep |=> sleep_flag // R3
        && core_halted ##1 (sleep_flag || $past(sleep_flag_clr)))
        else $error("sleep entry not recorded");

    a_idle_entry: assert property (s_enter_idle |=> idle_flag // R13
        && core_halted && post_count == '0)
        else $error("idle entry not recorded");

    a_sleep_wake: assert property (s_sleep_tmo |=> wake_pulse // R2
        && !core_halted && !dev_reset_req && timeout_flag)
        else $error("time-out in power save did not wake");

    a_count_in_save: assert property (!running && osc_en // R1
        && !wake_now && !ext_reset && !clock_switch_done |-> !scl_clr)
        else $error("counter cleared during power save");

    a_always_on: assert property (always_on_cfg |=> osc_en) // R4
        else $error("always-on watchdog was off");

    a_soft_off: assert property (!always_on_cfg && !soft_enable_bit // R5 R6
        |=> !osc_en)
        else $error("watchdog ran with soft enable clear");

    a_stopped_hold: assert property (!enabled // R6 R13
        |=> post_count == '0 && !osc_en)
        else $error("stopped watchdog kept a count");

    a_rst_soft_clr: assert property (dev_reset_req |-> !soft_enable_bit) // R7
        else $error("reset left soft enable set");

    a_flag_sticky: assert property (timeout_flag && !timeout_flag_clr // R8
        |=> timeout_flag [*1] ##0 $stable(timeout_flag))
        else $error("time-out flag dropped by itself");

    a_run_tmo_rst: assert property (tmo && running |=> dev_reset_req // R14
        && timeout_flag ##1 !core_halted)
        else $error("run time-out did not reset");

    a_plain_clear: assert property (window_off_cfg // R9 R13
        && clear_dog_instr && running && !tmo && !ext_reset
        |=> !dev_reset_req && post_count == '0)
        else $error("plain-mode clear misbehaved");

    // with a 1:1 or 1:2 postscale the widest window opens at zero, so skip both
    a_early_clear: assert property (clear_dog_instr && running // R15
        && enabled && !window_off_cfg && post_count == '0
        && post_limit(postscale_sel) > 16'h0002 |=> dev_reset_req)
        else $error("early clear did not reset");

endmodule : wdw_watchdog

// ### design/wdw_pkg.sv
package wdw_pkg;

    // clock rates and the enable-gated oscillator model
    localparam int CLK_HZ = 10_000_000;
    localparam int OSC_HZ = 32_000;
    localparam int OSC_DIV = CLK_HZ / OSC_HZ; // clk cycles per osc tick
    localparam int OSC_W = 9;
    localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_DIV - 1);

    // prescaler: 5-bit or 7-bit
    localparam int PRE_W = 7;
    localparam logic [PRE_W-1:0] PRE_LAST_32 = 7'h1f;
    localparam logic [PRE_W-1:0] PRE_LAST_128 = 7'h7f;

    // postscaler: 16 ratios, 1:1 up to 1:32768
    localparam int POST_W = 16;
    localparam logic [POST_W-1:0] POST_ONE = 16'h0001;

    // window select codes (window share of the period)
    localparam logic [1:0] WIN_75 = 2'h0;
    localparam logic [1:0] WIN_50 = 2'h1;
    localparam logic [1:0] WIN_37 = 2'h2;
    localparam logic [1:0] WIN_25 = 2'h3;

    // power-save state of the core
    typedef enum logic [2:0] {
        PWR_RUN = 3'b001,
        PWR_SLEEP = 3'b010,
        PWR_IDLE = 3'b100
    } wdw_pwr_t;

    // postscaler steps in one time-out period
    function automatic logic [POST_W-1:0] post_limit(input logic [3:0] sel);
        post_limit = POST_ONE << sel;
    endfunction : post_limit

    // postscaler step at which the clear window opens
    function automatic logic [POST_W-1:0] win_open(
        input logic [POST_W-1:0] lim,
        input logic [1:0] sel
    );
        case (sel)
            WIN_75: win_open = lim >> 2;
            WIN_50: win_open = lim >> 1;
            WIN_37: win_open = lim - (lim >> 2) - (lim >> 3);
            default: win_open = lim - (lim >> 2);
        endcase
    endfunction : win_open

endpackage : wdw_pkg

// ### design/wdw_scaler.sv
`timescale 1ns/100ps
module wdw_scaler import wdw_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic clr,
    input wire logic run,
    input wire logic prescale_sel,
    input wire logic [3:0] postscale_sel,
    // status
    output logic tmo,
    output logic [POST_W-1:0] post_count
);

    logic [OSC_W-1:0] osc_reg, osc_next;
    logic [PRE_W-1:0] pre_reg, pre_next;
    logic [POST_W-1:0] post_reg, post_next;
    logic tmo_reg, tmo_next;
    logic osc_tick;
    logic pre_wrap;
    logic [PRE_W-1:0] pre_last;

    assign tmo = tmo_reg;
    assign post_count = post_reg;
    assign osc_tick = run && (osc_reg == OSC_LAST);
    assign pre_last = prescale_sel ? PRE_LAST_128 : PRE_LAST_32;
    assign pre_wrap = osc_tick && (pre_reg == pre_last);

    // oscillator divide, prescale, postscale; osc only ticks when enabled
    always_comb begin
        osc_next = osc_reg;
        pre_next = pre_reg;
        post_next = post_reg;
        tmo_next = 1'b0;
        if (clr) begin // R13
            osc_next = '0;
            pre_next = '0;
            post_next = '0;
        end else if (run) begin // R11
            osc_next = osc_tick ? '0 : osc_reg + 1'b1;
            if (osc_tick) begin // R12
                pre_next = pre_wrap ? '0 : pre_reg + 1'b1;
            end
            if (pre_wrap) begin
                if (post_reg == post_limit(postscale_sel) - POST_ONE) begin
                    post_next = '0;
                    tmo_next = 1'b1;
                end else begin
                    post_next = post_reg + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_reg <= '0;
            pre_reg <= '0;
            post_reg <= '0;
            tmo_reg <= 1'b0;
        end else begin
            osc_reg <= osc_next;
            pre_reg <= pre_next;
            post_reg <= post_next;
            tmo_reg <= tmo_next;
        end
    end

    a_pre_advance: assert property (@(posedge clk) disable iff (rst) // R12
        osc_tick && !clr && !pre_wrap |=> pre_reg == $past(pre_reg) + 1'b1)
        else $error("prescaler did not advance on osc tick");

    a_clr_zeroes: assert property (@(posedge clk) disable iff (rst) // R13
        clr |=> post_reg == '0 && pre_reg == '0 && !tmo_reg)
        else $error("clear did not zero the scalers");

endmodule : wdw_scaler

// ### bench/tb.sv
`timescale 1ns/100ps
module tb;
    // clock, reset and fuse inputs
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic always_on_cfg = 1'b0;
    logic window_off_cfg = 1'b1;
    logic [1:0] window_size_sel = 2'h0;
    logic prescale_sel = 1'b0;
    logic [3:0] postscale_sel = 4'h0;
    // event pulses and register writes
    logic clear_dog_instr = 1'b0;
    logic power_save_instr = 1'b0;
    logic power_save_idle = 1'b0;
    logic wake_event = 1'b0;
    logic clock_switch_done = 1'b0;
    logic ext_reset = 1'b0;
    logic soft_enable_wr = 1'b0;
    logic soft_enable_wdata = 1'b0;
    logic timeout_flag_clr = 1'b0;
    logic sleep_flag_clr = 1'b0;
    logic idle_flag_clr = 1'b0;
    // outputs
    logic soft_enable_bit, timeout_flag, sleep_flag, idle_flag;
    logic osc_en, core_halted, wake_pulse, dev_reset_req;
    int n_errors = 0;
    int n_tests = 0;
    int n_rst = 0;
    int cyc = 0;
    int n;
    int r0;

    wdw_watchdog dut (.clk(clk), .rst(rst), .always_on_cfg(always_on_cfg),
        .window_off_cfg(window_off_cfg), .window_size_sel(window_size_sel),
        .prescale_sel(prescale_sel), .postscale_sel(postscale_sel),
        .clear_dog_instr(clear_dog_instr),
        .power_save_instr(power_save_instr),
        .power_save_idle(power_save_idle), .wake_event(wake_event),
        .clock_switch_done(clock_switch_done), .ext_reset(ext_reset),
        .soft_enable_wr(soft_enable_wr),
        .soft_enable_wdata(soft_enable_wdata),
        .timeout_flag_clr(timeout_flag_clr),
        .sleep_flag_clr(sleep_flag_clr), .idle_flag_clr(idle_flag_clr),
        .soft_enable_bit(soft_enable_bit), .timeout_flag(timeout_flag),
        .sleep_flag(sleep_flag), .idle_flag(idle_flag), .osc_en(osc_en),
        .core_halted(core_halted), .wake_pulse(wake_pulse),
        .dev_reset_req(dev_reset_req));

    // 100 ns period
    always #50 clk = ~clk;

    // reset requests are counted so no scenario can miss a one-cycle pulse
    always @(posedge clk) begin
        cyc++;
        if (dev_reset_req === 1'b1)
            n_rst++;
        if (cyc == 95000) begin
            n_errors++;
            $display("BAD %0t run too long", $time);
            tally_and_finish();
        end
    end

    task chk(input logic got, input logic exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk

    task tick(input int k);
        repeat (k) @(posedge clk);
    endtask : tick

    // one-cycle pulse on the selected event input
    task pulse(input int k);
        @(posedge clk);
        case (k)
            0: clear_dog_instr <= 1'b1;
            1: clock_switch_done <= 1'b1;
            2: ext_reset <= 1'b1;
            3: power_save_instr <= 1'b1;
            4: wake_event <= 1'b1;
            5: timeout_flag_clr <= 1'b1;
            6: sleep_flag_clr <= 1'b1;
            7: idle_flag_clr <= 1'b1;
            default: soft_enable_wr <= 1'b1;
        endcase
        @(posedge clk);
        {clear_dog_instr, clock_switch_done, ext_reset, power_save_instr,
            wake_event, timeout_flag_clr, sleep_flag_clr, idle_flag_clr,
            soft_enable_wr} <= 9'h000;
        @(negedge clk);
    endtask : pulse

    task soft_write(input logic v);
        @(posedge clk);
        soft_enable_wdata <= v;
        pulse(8);
    endtask : soft_write

    // bounded wait: 0 watches wake_pulse, 1 watches dev_reset_req
    task wait_out(input int which, input int max, output int cnt);
        cnt = 0;
        while ((which == 0 ? wake_pulse : dev_reset_req) !== 1'b1 &&
            cnt < max) begin
            @(negedge clk);
            cnt++;
        end
    endtask : wait_out

    task t_soft;
        chk(soft_enable_bit | osc_en | timeout_flag, 1'b0, "at reset");
        soft_write(1'b1);
        tick(2);
        chk(osc_en, 1'b1, "osc off while enabled");
        pulse(2);
        chk(soft_enable_bit, 1'b0, "enable kept over reset");
        tick(2);
        r0 = n_rst;
        tick(11000);
        chk(n_rst == r0 && osc_en === 1'b0, 1'b1, "ran while off");
    endtask : t_soft

    task t_run_timeout;
        soft_write(1'b1);
        wait_out(1, 11000, n);
        chk(n > 9600 && n < 11000, 1'b1, "run period wrong");
        @(negedge clk);
        chk(timeout_flag & ~soft_enable_bit, 1'b1, "run time-out");
        tick(50);
        chk(timeout_flag, 1'b1, "flag not sticky");
        pulse(5);
        chk(timeout_flag, 1'b0, "flag clear failed");
    endtask : t_run_timeout

    task t_always_on;
        @(posedge clk);
        always_on_cfg <= 1'b1;
        soft_write(1'b0);
        tick(3);
        chk(osc_en, 1'b1, "always on ignored");
        power_save_idle <= 1'b0;
        pulse(3);
        chk(core_halted & sleep_flag, 1'b1, "sleep entry");
        tick(100);
        pulse(4);
        wait_out(0, 5, n);
        chk(n < 5 && timeout_flag === 1'b0, 1'b1, "wake source");
        pulse(6);
        @(posedge clk);
        power_save_idle <= 1'b1;
        r0 = n_rst;
        pulse(3);
        chk(core_halted & idle_flag, 1'b1, "idle entry");
        wait_out(0, 11000, n);
        chk(n > 9600 && n < 11000, 1'b1, "idle time-out missing");
        @(negedge clk);
        chk(timeout_flag & ~core_halted, 1'b1, "idle wake");
        chk(n_rst == r0, 1'b1, "reset on wake");
        pulse(7);
        pulse(5);
        chk(idle_flag | timeout_flag, 1'b0, "flags not cleared");
    endtask : t_always_on

    // clear, clock switch and device reset each restart the count
    task t_restart;
        r0 = n_rst;
        for (int k = 0; k < 3; k++) begin
            tick(5000);
            pulse(k);
        end
        tick(5000);
        chk(n_rst == r0, 1'b1, "count not restarted");
    endtask : t_restart

    task t_window;
        postscale_sel <= 4'h2;
        for (int c = 0; c < 5; c++) begin
            window_size_sel <= 2'(c);
            window_off_cfg <= (c == 4);
            pulse(2);
            r0 = n_rst;
            pulse(0);
            tick(3);
            chk(n_rst == r0 + (c < 4), 1'b1, "early clear");
        end
        window_size_sel <= 2'h0;
        window_off_cfg <= 1'b0;
        pulse(2);
        r0 = n_rst;
        tick(12000);
        pulse(0);
        tick(3);
        chk(n_rst == r0, 1'b1, "clear in window faulted");
        // the slow prescaler keeps the window shut where the fast one opened
        prescale_sel <= 1'b1;
        postscale_sel <= 4'h1;
        window_size_sel <= 2'h1;
        pulse(2);
        r0 = n_rst;
        tick(15000);
        pulse(0);
        tick(3);
        chk(n_rst == r0 + 1, 1'b1, "slow prescale not seen");
    endtask : t_window

    task tally_and_finish;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    initial begin
        tick(20);
        rst <= 1'b0;
        @(negedge clk);
        t_soft();
        t_run_timeout();
        t_always_on();
        t_restart();
        t_window();
        tally_and_finish();
    end
endmodule : tb
